// file: rtl/port_cfg_pkg.sv
package port_cfg_pkg;

    // ****************************************************************
    // Clock and input qualification timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 20;
    localparam int GLITCH_REJECT_NS = 60;
    // A least time: round up to whole cycles, never below one.
    localparam int FILTER_CYCLES_RAW = (GLITCH_REJECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FILTER_CYCLES = (FILTER_CYCLES_RAW < 1) ? 1 : FILTER_CYCLES_RAW;
    localparam int FILTER_CNT_W = $clog2(FILTER_CYCLES + 1);

    // ****************************************************************
    // Register word indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [3:0] PORT0_LATCH_IDX = 4'h0;
    localparam logic [3:0] PORT0_CFG1_IDX = 4'h1;
    localparam logic [3:0] PORT0_CFG2_IDX = 4'h2;
    localparam logic [3:0] PORT0_PINS_IDX = 4'h3;
    localparam logic [3:0] PORT1_LATCH_IDX = 4'h4;
    localparam logic [3:0] PORT1_CFG1_IDX = 4'h5;
    localparam logic [3:0] PORT1_CFG2_IDX = 4'h6;
    localparam logic [3:0] PORT1_PINS_IDX = 4'h7;
    localparam logic [3:0] PORT3_LATCH_IDX = 4'h8;
    localparam logic [3:0] PORT3_CFG1_IDX = 4'h9;
    localparam logic [3:0] PORT3_CFG2_IDX = 4'hA;
    localparam logic [3:0] PORT3_PINS_IDX = 4'hB;
    localparam logic [3:0] DIN_DISABLE_IDX = 4'hC;

    // ****************************************************************
    // Reset values and fixed-bit masks
    // ****************************************************************
    localparam logic [7:0] LATCH_RESET = 8'hFF;
    localparam logic [7:0] CFG1_RESET = 8'hFF;
    localparam logic [7:0] CFG2_RESET = 8'h00;
    localparam logic [7:0] DIN_DISABLE_RESET = 8'h00;
    localparam logic [7:0] DIN_DISABLE_MASK = 8'h3E;
    localparam logic [7:0] PORT0_PIN_MASK = 8'hFF;
    localparam logic [7:0] PORT1_PIN_MASK = 8'hFF;
    localparam logic [7:0] PORT3_PIN_MASK = 8'h03;
    // Port 1 pins 2, 3 and 5 have cfg1 tied high; pin 5 also has cfg2 tied low.
    localparam logic [7:0] PORT1_CFG1_FORCE_ONE = 8'h2C;
    localparam logic [7:0] PORT1_CFG2_FORCE_ZERO = 8'h20;
    localparam int RESET_SHARED_INPUT_BIT = 5;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        PIN_QUASI = 2'b00,
        PIN_PUSH_PULL = 2'b01,
        PIN_INPUT_ONLY = 2'b10,
        PIN_OPEN_DRAIN = 2'b11
    } pin_type_t;

    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ANSWER = 1'b1
    } bus_state_t;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] weak_pullup;
    } port_drive_t;

    typedef struct packed {
        logic [3:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } avmm_req_t;

endpackage

// file: rtl/pin_qualifier.sv
module pin_qualifier
    import port_cfg_pkg::*;
#(
    parameter int CYCLES = FILTER_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic raw,
    output logic level
);

    logic [FILTER_CNT_W-1:0] count;

    // A new level is taken only after it has differed from the held level for CYCLES
    // consecutive samples; shorter pulses are dropped without a trace.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            count <= '0;
            level <= 1'b0;
        end else if (ce) begin
            if (raw == level) begin
                count <= '0;
            end else if (count == FILTER_CNT_W'(CYCLES - 1)) begin
                count <= '0;
                level <= raw;
            end else begin
                count <= count + FILTER_CNT_W'(1);
            end
        end
    end

endmodule

// file: rtl/port_pin_output_type_config.sv
// Behaviour
// - Every configurable pin except port 1 pins 2 and 3 independently takes quasi, push-pull, open-drain or input-only.
// - Each port has two configuration registers; matching bits pick each pin's type.
// - The reset-shared input pin is always input-only; its configuration writes are ignored.
// - The two I2C-shared pins accept only input-only or open-drain types.
// - Quasi type: latch one gives weak high only, latch zero drives strong low.
// - Open-drain type: pull-ups off, pull-down on only while latch holds zero.
// - Input-only type: all drivers off, pin high impedance whatever the latch holds.
// - Push-pull type: strong low for latch zero, continuous strong high for one.
// - Every pin level passes a glitch-suppressing qualifier before the digital input path.
// - Analog-port disable bits one to five gate off digital inputs when set.
// - Every reset clears the implemented digital-input-disable bits to zero.
// - After power-up every pin is input-only until software changes it.
// - During reset pins stay input-only with the internal pull-up disabled.
//
// The Avalon-MM interface to the registers and the placing of the registers were chosen for this implementation.
module port_pin_output_type_config
    import port_cfg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [7:0] port0_pin_in,
    input wire logic [7:0] port1_pin_in,
    input wire logic [1:0] port3_pin_in,
    output port_drive_t port0_drive,
    output port_drive_t port1_drive,
    output port_drive_t port3_drive,
    output logic [7:0] port0_digital_in,
    output logic [7:0] port1_digital_in,
    output logic [1:0] port3_digital_in
);

    // ****************************************************************
    // Storage
    // ****************************************************************
    logic [7:0] latch [3];
    logic [7:0] cfg1 [3];
    logic [7:0] cfg2 [3];
    logic [7:0] din_disable;
    bus_state_t bus_state;
    avmm_req_t req;

    logic [7:0] pin_mask [3];
    logic [7:0] cfg1_eff [3];
    logic [7:0] cfg2_eff [3];
    logic [7:0] qualified [3];
    logic [7:0] raw_pins [3];
    port_drive_t drive [3];

    assign req.address = avs_address;
    assign req.read = avs_read;
    assign req.write = avs_write;
    assign req.writedata = avs_writedata;
    assign req.byteenable = avs_byteenable;

    assign pin_mask[0] = PORT0_PIN_MASK;
    assign pin_mask[1] = PORT1_PIN_MASK;
    assign pin_mask[2] = PORT3_PIN_MASK;

    assign raw_pins[0] = port0_pin_in;
    assign raw_pins[1] = port1_pin_in;
    assign raw_pins[2] = {6'h00, port3_pin_in};

    // ****************************************************************
    // Bus handshake
    // ****************************************************************
    // Every access with ce held high takes exactly one wait state so read data can come from a flop.
    // The answer edge is the second rising edge after the request appears (ce high).
    // Waitrequest stays high on any edge with ce low, because nothing lands there and
    // the master must not release a request that the frozen logic has not served.
    logic bus_ack;
    assign bus_ack = (bus_state == BUS_ANSWER);
    assign avs_waitrequest = (req.read || req.write) && !(bus_ack && ce);

    // The answer state lasts one edge; a request held after it is taken again next edge.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bus_state <= BUS_IDLE;
        end else if (ce) begin
            case (bus_state)
                BUS_IDLE: begin
                    if (req.read || req.write) begin
                        bus_state <= BUS_ANSWER;
                    end
                end
                BUS_ANSWER: begin
                    bus_state <= BUS_IDLE;
                end
                default: begin
                    bus_state <= BUS_IDLE;
                end
            endcase
        end
    end

    // A write lands on the same edge at which the master sees waitrequest low.
    // A read is loaded on the taking edge and held, so it still stands at the answer edge.
    // Only byte lane zero carries register data; the upper lanes are ignored.
    logic wr_fire;
    logic rd_fire;
    assign wr_fire = ce && bus_ack && req.write && req.byteenable[0];
    assign rd_fire = ce && (bus_state == BUS_IDLE) && req.read;

    // ****************************************************************
    // Port latches and configuration registers
    // ****************************************************************
    // Port index 0, 1, 2 stand for ports 0, 1 and 3; each port owns four words.
    // Writes to the pins word, to unmapped words or without the low byte lane are dropped.
    logic [1:0] wr_port;
    logic [1:0] wr_field;
    logic port_wr;
    assign wr_port = req.address[3:2];
    assign wr_field = req.address[1:0];
    assign port_wr = wr_fire && (wr_port != 2'b11);

    // Absent port 3 positions reset to zero as well, so they read back as zero.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            latch[0] <= LATCH_RESET & PORT0_PIN_MASK;
            latch[1] <= LATCH_RESET & PORT1_PIN_MASK;
            latch[2] <= LATCH_RESET & PORT3_PIN_MASK;
        end else if (port_wr && wr_field == 2'b00) begin
            latch[wr_port] <= req.writedata[7:0] & pin_mask[wr_port];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cfg1[0] <= CFG1_RESET & PORT0_PIN_MASK;
            cfg1[1] <= CFG1_RESET & PORT1_PIN_MASK;
            cfg1[2] <= CFG1_RESET & PORT3_PIN_MASK;
        end else if (port_wr && wr_field == 2'b01) begin
            cfg1[wr_port] <= req.writedata[7:0] & pin_mask[wr_port];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cfg2[0] <= CFG2_RESET & PORT0_PIN_MASK;
            cfg2[1] <= CFG2_RESET & PORT1_PIN_MASK;
            cfg2[2] <= CFG2_RESET & PORT3_PIN_MASK;
        end else if (port_wr && wr_field == 2'b10) begin
            cfg2[wr_port] <= req.writedata[7:0] & pin_mask[wr_port];
        end
    end

    // Bits zero, six and seven have no gate and always read as zero.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            din_disable <= DIN_DISABLE_RESET;
        end else if (wr_fire && req.address == DIN_DISABLE_IDX) begin
            din_disable <= req.writedata[7:0] & DIN_DISABLE_MASK;
        end
    end

    // ****************************************************************
    // Effective pin types
    // ****************************************************************
    // Restricted pins have their configuration bits tied, so a forbidden code can
    // never reach the driver: quasi falls to input-only, push-pull to open-drain.
    // Port 1 pin 5 is fixed to input-only; pins 2 and 3 keep only their second bit.
    always_comb begin
        cfg1_eff[0] = cfg1[0];
        cfg2_eff[0] = cfg2[0];
        cfg1_eff[1] = cfg1[1] | PORT1_CFG1_FORCE_ONE;
        cfg2_eff[1] = cfg2[1] & ~PORT1_CFG2_FORCE_ZERO;
        cfg1_eff[2] = cfg1[2];
        cfg2_eff[2] = cfg2[2];
    end

    // The encoding is fixed by pin_type_t: {cfg1, cfg2}.
    // Quasi high is weak only, so an outside driver may pull the pin low and be read back.
    function automatic logic [2:0] pin_drive(input pin_type_t kind, input logic latched);
        logic [2:0] d;
        d = 3'b000;
        case (kind)
            PIN_QUASI: begin
                d = latched ? 3'b001 : 3'b010;
            end
            PIN_PUSH_PULL: begin
                d = {latched, 1'b1, 1'b0};
            end
            PIN_OPEN_DRAIN: begin
                d = {1'b0, ~latched, 1'b0};
            end
            PIN_INPUT_ONLY: begin
                d = 3'b000;
            end
            default: begin
                d = 3'b000;
            end
        endcase
        return d;
    endfunction

    // Bits are {out, oe, weak_pullup}; oe drives strongly at the level of out.
    // Masking by pin_mask keeps absent port 3 positions quiet whatever the registers hold.
    always_comb begin
        logic [2:0] d;
        d = 3'b000;
        for (int p = 0; p < 3; p++) begin
            drive[p] = '0;
            for (int b = 0; b < 8; b++) begin
                d = pin_drive(pin_type_t'({cfg1_eff[p][b], cfg2_eff[p][b]}),
                              latch[p][b]);
                drive[p].out[b] = d[2] & pin_mask[p][b];
                drive[p].oe[b] = d[1] & pin_mask[p][b];
                drive[p].weak_pullup[b] = d[0] & pin_mask[p][b];
            end
        end
    end

    // While reset is held, every driver and pull-up is forced off regardless of state.
    always_comb begin
        if (rst) begin
            port0_drive = '0;
            port1_drive = '0;
            port3_drive = '0;
        end else begin
            port0_drive = drive[0];
            port1_drive = drive[1];
            port3_drive = drive[2];
        end
    end

    // ****************************************************************
    // Input qualification
    // ****************************************************************
    // All implemented pins are qualified whatever their type, including input-only.
    // Qualified levels reset low, so idle-high pins show one rising step on the digital
    // inputs four cycles after reset; peripherals should ignore that first edge.
    // Positions without a pin are tied low so reads and digital inputs show zero there.
    genvar gp;
    genvar gb;
    generate
        for (gp = 0; gp < 3; gp++) begin : g_port
            for (gb = 0; gb < 8; gb++) begin : g_bit
                if ((gp < 2) || (gb < 2)) begin : g_used
                    pin_qualifier #(
                        .CYCLES(FILTER_CYCLES)
                    ) u_qual (
                        .ref_clk(ref_clk),
                        .rst(rst),
                        .ce(ce),
                        .raw(raw_pins[gp][gb]),
                        .level(qualified[gp][gb])
                    );
                end else begin : g_unused
                    assign qualified[gp][gb] = 1'b0;
                end
            end
        end
    endgenerate

    // The disable gate costs one cycle but keeps the peripheral-facing inputs glitch free.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            port0_digital_in <= 8'h00;
            port1_digital_in <= 8'h00;
            port3_digital_in <= 2'h0;
        end else if (ce) begin
            port0_digital_in <= qualified[0] & ~din_disable;
            port1_digital_in <= qualified[1];
            port3_digital_in <= qualified[2][1:0];
        end
    end

    // ****************************************************************
    // Read data
    // ****************************************************************
    // Configuration reads show the effective bits, so tied bits read as tied.
    logic [7:0] rd_byte;

    always_comb begin
        rd_byte = 8'h00;
        case (req.address)
            PORT0_LATCH_IDX: begin
                rd_byte = latch[0];
            end
            PORT0_CFG1_IDX: begin
                rd_byte = cfg1_eff[0];
            end
            PORT0_CFG2_IDX: begin
                rd_byte = cfg2_eff[0];
            end
            PORT0_PINS_IDX: begin
                rd_byte = port0_digital_in;
            end
            PORT1_LATCH_IDX: begin
                rd_byte = latch[1];
            end
            PORT1_CFG1_IDX: begin
                rd_byte = cfg1_eff[1];
            end
            PORT1_CFG2_IDX: begin
                rd_byte = cfg2_eff[1];
            end
            PORT1_PINS_IDX: begin
                rd_byte = port1_digital_in;
            end
            PORT3_LATCH_IDX: begin
                rd_byte = latch[2];
            end
            PORT3_CFG1_IDX: begin
                rd_byte = cfg1_eff[2];
            end
            PORT3_CFG2_IDX: begin
                rd_byte = cfg2_eff[2];
            end
            PORT3_PINS_IDX: begin
                rd_byte = {6'h00, port3_digital_in};
            end
            DIN_DISABLE_IDX: begin
                rd_byte = din_disable;
            end
            default: begin
                rd_byte = 8'h00;
            end
        endcase
    end

    // Only the taking edge loads read data; the answer edge sees it unchanged.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (rd_fire) begin
            avs_readdata <= {24'h00_0000, rd_byte};
        end
    end

endmodule

// file: dv/port_cfg_chk.sv
// ****************************************************************
// Port checker
// ****************************************************************
module port_cfg_chk
    import port_cfg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [7:0] port1_pin_in,
    input wire port_drive_t port0_drive,
    input wire port_drive_t port1_drive,
    input wire port_drive_t port3_drive,
    input wire logic [7:0] port1_digital_in
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    // The reset check must stay live while reset is high, so it overrides the default.
    reset_drive_a: assert property (disable iff (1'b0) rst |->
        (port0_drive == '0 && port1_drive == '0 && port3_drive == '0))
        else $error("drives not off in reset");
    shared_pin_a: assert property ({port1_drive.out[5], port1_drive.oe[5],
        port1_drive.weak_pullup[5]} == 3'h0)
        else $error("reset-shared pin driven");
    i2c_pins_a: assert property (port1_drive.weak_pullup[3:2] == 2'h0 &&
        port1_drive.out[3:2] == 2'h0)
        else $error("i2c pin driven high");
    drive_excl_a: assert property (((port0_drive.oe & port0_drive.weak_pullup) |
        (port1_drive.oe & port1_drive.weak_pullup)) == 8'h00)
        else $error("strong and weak drive together");
    wait_fall_a: assert property ((avs_read || avs_write) && avs_waitrequest && ce
        |=> !avs_waitrequest || !ce)
        else $error("waitrequest held too long");
    wait_cause_a: assert property (avs_waitrequest |-> (avs_read || avs_write))
        else $error("waitrequest without request");
    unmapped_read_a: assert property (avs_read && !avs_waitrequest && avs_address > 4'hC
        |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    glitch_filter_a: assert property ($changed(port1_digital_in) |->
        $past(port1_pin_in, 2) == $past(port1_pin_in, 3))
        else $error("input passed without qualification");
endmodule

bind port_pin_output_type_config port_cfg_chk port_cfg_chk_inst (.ref_clk, .rst, .ce,
    .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .port1_pin_in,
    .port0_drive, .port1_drive, .port3_drive, .port1_digital_in);

// file: dv/port_pin_output_type_config_tb_top.sv
module port_pin_output_type_config_tb_top
    import port_cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic ref_clk, rst, ce, avs_read, avs_write, avs_waitrequest;
    logic [3:0] avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata;
    logic [7:0] port0_pin_in, port1_pin_in, port0_digital_in, port1_digital_in;
    logic [1:0] port3_pin_in, port3_digital_in;
    port_drive_t port0_drive, port1_drive, port3_drive;
    int errors = 0;
    int samples_checked = 0;

    port_pin_output_type_config port_pin_output_type_config_inst (.ref_clk, .rst, .ce,
        .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
        .avs_waitrequest, .port0_pin_in, .port1_pin_in, .port3_pin_in, .port0_drive,
        .port1_drive, .port3_drive, .port0_digital_in, .port1_digital_in, .port3_digital_in);

    // ****************************************************************
    // Bus and compare tasks
    // ****************************************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Waits on waitrequest alone; only the watchdog ends a wait on a hung slave.
    task automatic bus(input logic rd, input logic [3:0] a, input logic [7:0] d,
                       output logic [31:0] q);
        @(posedge ref_clk);
        avs_read <= rd;
        avs_write <= ~rd;
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        do begin
            @(posedge ref_clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b0, a, d, q);
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b1, a, 8'h00, q);
        check(q, e);
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic test_reset();
        rd_chk(PORT0_CFG1_IDX, 32'hFF);
        rd_chk(PORT0_CFG2_IDX, 32'h00);
        rd_chk(PORT3_CFG1_IDX, 32'h03);
        rd_chk(DIN_DISABLE_IDX, 32'h00);
        check(32'(port0_drive), 32'h0);
        check(32'(port3_drive), 32'h0);
    endtask

    task automatic test_types();
        logic [7:0] l;
        port_drive_t e;
        l = 8'h5A;
        wr(PORT0_LATCH_IDX, l);
        for (int t = 0; t < 4; t++) begin
            wr(PORT0_CFG1_IDX, {8{t[1]}});
            wr(PORT0_CFG2_IDX, {8{t[0]}});
            case (t)
                0: e = {8'h00, ~l, l};
                1: e = {l, 8'hFF, 8'h00};
                2: e = '0;
                default: e = {8'h00, ~l, 8'h00};
            endcase
            @(posedge ref_clk);
            check(32'(port0_drive), 32'(e));
        end
        // The board's pull-up lifts released open-drain pins, so the latch reads back.
        port0_pin_in <= ~port0_drive.oe | port0_drive.out;
        repeat (5) @(posedge ref_clk);
        check(32'(port0_digital_in), 32'(l));
        port0_pin_in <= 8'hFF;
    endtask

    task automatic test_locked();
        wr(PORT1_CFG1_IDX, 8'h00);
        wr(PORT1_CFG2_IDX, 8'hFF);
        wr(PORT1_LATCH_IDX, 8'h00);
        @(posedge ref_clk);
        check(32'(port1_drive), 32'h00DF00);
        rd_chk(PORT1_CFG1_IDX, 32'h2C);
        rd_chk(PORT1_CFG2_IDX, 32'hDF);
        wr(PORT1_LATCH_IDX, 8'hFF);
        @(posedge ref_clk);
        check(32'(port1_drive), 32'hD3D300);
        wr(PORT1_CFG2_IDX, 8'h00);
        @(posedge ref_clk);
        check(32'(port1_drive), 32'h0000D3);
    endtask

    task automatic test_filter();
        @(posedge ref_clk);
        port1_pin_in <= 8'hFE;
        repeat (2) @(posedge ref_clk);
        check(32'(port1_digital_in), 32'hFF);
        port1_pin_in <= 8'hFF;
        repeat (8) @(posedge ref_clk);
        check(32'(port1_digital_in), 32'hFF);
        port1_pin_in <= 8'hFE;
        repeat (4) @(posedge ref_clk);
        check(32'(port1_digital_in), 32'hFF);
        @(posedge ref_clk);
        check(32'(port1_digital_in), 32'hFE);
        // Clock enable low freezes the qualifier and the input register.
        ce <= 1'b0;
        port1_pin_in <= 8'hFF;
        repeat (8) @(posedge ref_clk);
        check(32'(port1_digital_in), 32'hFE);
        ce <= 1'b1;
        repeat (5) @(posedge ref_clk);
        check(32'(port1_digital_in), 32'hFF);
    endtask

    task automatic test_disable();
        wr(PORT0_CFG1_IDX, 8'hFF);
        wr(PORT0_CFG2_IDX, 8'h00);
        @(posedge ref_clk);
        check(32'(port0_drive), 32'h0);
        wr(DIN_DISABLE_IDX, 8'hFF);
        rd_chk(DIN_DISABLE_IDX, 32'h3E);
        repeat (3) @(posedge ref_clk);
        check(32'(port0_digital_in), 32'hC1);
        rd_chk(PORT0_PINS_IDX, 32'hC1);
        rd_chk(4'hD, 32'h0);
        avs_byteenable <= 4'h0;
        wr(DIN_DISABLE_IDX, 8'h00);
        avs_byteenable <= 4'hF;
        rd_chk(DIN_DISABLE_IDX, 32'h3E);
        // A second reset in mid-run must restore the disable bits and switch off the port 1 drives.
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        rd_chk(DIN_DISABLE_IDX, 32'h00);
        check(32'(port1_drive), 32'h0);
    endtask

    // ****************************************************************
    // Run control
    // ****************************************************************
    task automatic close_out();
        if (errors == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        port0_pin_in = 8'hFF;
        port1_pin_in = 8'hFF;
        port3_pin_in = 2'h3;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        test_reset();
        test_types();
        test_locked();
        test_filter();
        test_disable();
        close_out();
    end

    initial begin
        #(20 * 20000);
        errors++;
        close_out();
    end
endmodule
